// File: design/ets_pkg.sv
// Shared constants, types and register map of the event timing sequencer.
// Assumes a 20 MHz system clock and a word-addressed Avalon-MM register port.
package ets_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned SHORT_TIME_NS  = 8000;
  localparam int unsigned SHORT_CYC      = SHORT_TIME_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned OPEN_TIME_NS   = 2000;
  localparam int unsigned OPEN_CYC       = OPEN_TIME_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned PORT_UNIT_US   = 128;
  localparam int unsigned PORT_UNIT_CYC  = PORT_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LSB_UNIT_NS    = 1_953_125;
  localparam int unsigned LSB_UNIT_CYC   = LSB_UNIT_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned FIRST_UNITS    = 1024;
  localparam int unsigned RAND_MIN_STEPS = 42;
  localparam int unsigned TEMP_STEP_SH   = 8;
  localparam logic [8:0]  LFSR_SEED      = 9'h1FF;
  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_TIMING = 4'h1;
  localparam logic [3:0]  REG_STATUS = 4'h2;
  localparam logic [3:0]  REG_FSTAT  = 4'h3;
  localparam logic [3:0]  REG_DAVG   = 4'h4;
  localparam logic [3:0]  REG_TAVG   = 4'h5;
  localparam logic [3:0]  REG_TRES   = 4'h6;
  localparam logic [3:0]  REG_TCNT   = 4'h7;
  localparam int CTRL_CMD   = 0;
  localparam int CTRL_HALT  = 2;
  localparam int CTRL_CONT  = 4;
  localparam int CTRL_PMI   = 5;
  localparam int CTRL_IRQEN = 6;
  localparam int CTRL_PCT   = 8;
  localparam int CTRL_CAL   = 12;
  localparam int TIM_FRATE  = 0;
  localparam int TIM_FCNT   = 8;
  localparam int TIM_TRATE  = 16;
  localparam int TIM_TCNT   = 24;
  localparam int ST_FDONE   = 0;
  localparam int ST_TDONE   = 1;
  localparam int ST_TMO     = 2;
  localparam int ST_FMEAS   = 3;
  localparam int ST_TMEAS   = 4;
  localparam int ST_BUSY    = 8;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] TIMING_RST = 32'h0000_0000;
  localparam logic [15:0] SHORT_VAL  = 16'h0000;
  localparam logic [15:0] OPEN_VAL   = 16'hFFFF;
  // ----------------------------------------
  // Commands and types
  // ----------------------------------------
  localparam logic [1:0] CMD_NONE   = 2'h0;
  localparam logic [1:0] CMD_BOTH   = 2'h1;
  localparam logic [1:0] CMD_FLIGHT = 2'h2;
  localparam logic [1:0] CMD_TEMP   = 2'h3;
  typedef enum logic [2:0] {S_IDLE, S_RUN, S_CAL, S_FLIGHT, S_TEMP} ets_state_t;
  typedef struct packed {
    ets_state_t   state;
    logic [1:0]   mode;
    logic         cont, pmi, irqen, cal_en, cal_tmp;
    logic [1:0]   pct;
    logic [3:0]   frate;
    logic [4:0]   fcnt;
    logic [5:0]   trate;
    logic [4:0]   tcnt;
    logic [4:0]   stat;
    logic [15:0]  unit_cnt;
    logic [3:0]   step_div;
    logic         first;
    logic [10:0]  ftimer, ftarget;
    logic [14:0]  ttimer;
    logic [8:0]   lfsr;
    logic         fpend, tpend;
    logic [5:0]   fsched, fissued, fvalid;
    logic [5:0]   tsched, tissued, tvalid;
    logic [20:0]  fsum, tsum0, tsum1;
    logic [15:0]  fmax, fmin, favg, fspread;
    logic [15:0]  tavg0, tavg1, tres0, tres1;
    logic         tport, tbad;
    logic [15:0]  tcyc;
    logic         fstart, tstart, cstart, irq_n, waitreq;
    logic [31:0]  rdata;
  } ets_st_t;
endpackage : ets_pkg

// File: design/ets_sequencer.sv
// Event timing sequencer: schedules flight-time and temperature commands,
// gathers statistics and drives the interrupt pin.
// Assumes flight and calibration engines answer start pulses with done pulses, and
// an Avalon-MM master on the register port, all on clk.
//
// Summary of operation
// - Port discharge under 8 us means shorted probe; result 0000h.
// - No discharge by port cycle time plus 2 us means open probe.
// - Open probe loads FFFFh, sets timeout flag, drives enabled interrupt.
// - Any other temperature failure loads FFFFh into every port result.
// - Three automatic commands: flight only, temperature only, both.
// - Continuous bit set restarts the sequence until halted.
// - Continuous bit clear stops after one full sequence.
// - Per-measurement bit 1 interrupts after every measurement.
// - Per-measurement bit 0 interrupts only at end of the flight or temperature series, or on timeout.
// - 9-bit LFSR with x^9+x^5+1 randomizes flight sample spacing.
// - Later flight samples start at randomized intervals from previous start.
// - 4-bit rate code; first sample one nominal period after start.
// - Intervals start to start, 0.082 s to about 16 s at slowest.
// - Flight valid count rises only on error-free measurements.
// - Spread holds largest minus smallest valid flight difference.
// - Temperature count rises after each error-free temperature measurement.
// - Erroneous temperature measurements never update the averages.
// - Each error-free flight command takes upstream minus downstream, updates average.
// - 4-bit rate field and 5-bit count field set the flight sequence.
// - After last average update, set flight done flag and interrupt.
// - Optional calibration before measurements; its errors handled elsewhere.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ets_sequencer #(
  parameter int unsigned UNIT_CYC = ets_pkg::LSB_UNIT_CYC
) (
  // Clock and reset
  input  logic        clk,
  input  logic        rst,
  // Avalon-MM slave
  input  logic [3:0]  avs_address,
  input  logic        avs_read,
  input  logic        avs_write,
  input  logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic        avs_waitrequest,
  // Flight-time engine
  output logic        flight_start,
  input  logic        flight_done,
  input  logic        flight_error,
  input  logic [15:0] upstream_average,
  input  logic [15:0] downstream_average,
  // Calibration engine
  output logic        cal_start,
  input  logic        cal_done,
  // Temperature engine
  output logic        temp_start,
  output logic        temp_port_sel,
  input  logic        timing_cap_pin,
  input  logic        temp_error_other,
  // Interrupt pin
  output logic        irq_n
);
  ets_pkg::ets_st_t s_r, s_nxt;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] port_lim(input logic [1:0] pct);
    port_lim = 16'(({14'h0000, pct} + 16'h0001) * ets_pkg::PORT_UNIT_CYC);
  endfunction : port_lim

  function automatic logic [15:0] avg_of(input logic [20:0] sum, input logic [5:0] n, input logic sgn);
    logic signed [21:0] q;
    q = 22'sh000000;
    if (n != 6'h00) begin
      if (sgn) q = $signed({sum[20], sum}) / $signed({16'h0000, n});
      else     q = $signed({1'b0, sum}) / $signed({16'h0000, n});
    end
    avg_of = q[15:0];
  endfunction : avg_of

  function automatic logic [10:0] rnd_steps(input logic [8:0] l);
    rnd_steps = (l < 9'(ets_pkg::RAND_MIN_STEPS)) ? 11'(ets_pkg::RAND_MIN_STEPS) : {2'h0, l};
  endfunction : rnd_steps

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic        wr_ok, do_restart, utick, stick, fuse, tuse, fin, bad_now, last_port;
  logic [5:0]  ftot, ttot;
  logic [14:0] tlim;
  logic [15:0] diff, pres;
  logic [20:0] dsum;

  always_comb begin
    s_nxt      = s_r;
    do_restart = 1'b0;
    bad_now    = 1'b0;
    pres       = 16'h0000;
    last_port  = 1'b0;
    diff       = 16'(upstream_average - downstream_average);
    dsum       = 21'(s_r.fsum + {{5{diff[15]}}, diff});
    s_nxt.fstart = 1'b0;
    s_nxt.tstart = 1'b0;
    s_nxt.cstart = 1'b0;
    fuse = (s_r.mode == ets_pkg::CMD_BOTH) || (s_r.mode == ets_pkg::CMD_FLIGHT);
    tuse = (s_r.mode == ets_pkg::CMD_BOTH) || (s_r.mode == ets_pkg::CMD_TEMP);
    ftot = {1'b0, s_r.fcnt} + 6'h01;
    ttot = {1'b0, s_r.tcnt} + 6'h01;
    tlim = 15'({1'b0, s_r.trate} + 7'h01) << ets_pkg::TEMP_STEP_SH;
    // Bus slave: one wait cycle, write lands on the released edge
    wr_ok = avs_write & ~s_r.waitreq;
    s_nxt.waitreq = 1'b1;
    if ((avs_read | avs_write) & s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      unique case (avs_address)
        ets_pkg::REG_CTRL:   s_nxt.rdata = {19'h0, s_r.cal_en, 2'h0, s_r.pct, 1'b0, s_r.irqen,
                                            s_r.pmi, s_r.cont, 2'h0, s_r.mode};
        ets_pkg::REG_TIMING: s_nxt.rdata = {3'h0, s_r.tcnt, 2'h0, s_r.trate, 3'h0, s_r.fcnt,
                                            4'h0, s_r.frate};
        ets_pkg::REG_STATUS: s_nxt.rdata = {23'h0, s_r.state != ets_pkg::S_IDLE, 3'h0, s_r.stat};
        ets_pkg::REG_FSTAT:  s_nxt.rdata = {s_r.fspread, 10'h000, s_r.fvalid};
        ets_pkg::REG_DAVG:   s_nxt.rdata = {16'h0000, s_r.favg};
        ets_pkg::REG_TAVG:   s_nxt.rdata = {s_r.tavg1, s_r.tavg0};
        ets_pkg::REG_TRES:   s_nxt.rdata = {s_r.tres1, s_r.tres0};
        ets_pkg::REG_TCNT:   s_nxt.rdata = {26'h0, s_r.tvalid};
        default:             s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_ok) begin
      unique case (avs_address)
        ets_pkg::REG_CTRL: begin
          s_nxt.cont   = avs_writedata[ets_pkg::CTRL_CONT];
          s_nxt.pmi    = avs_writedata[ets_pkg::CTRL_PMI];
          s_nxt.irqen  = avs_writedata[ets_pkg::CTRL_IRQEN];
          s_nxt.pct    = avs_writedata[ets_pkg::CTRL_PCT +: 2];
          s_nxt.cal_en = avs_writedata[ets_pkg::CTRL_CAL];
          if (avs_writedata[ets_pkg::CTRL_HALT]) begin
            s_nxt.state = ets_pkg::S_IDLE;
          end else if (s_r.state == ets_pkg::S_IDLE &&
                       avs_writedata[ets_pkg::CTRL_CMD +: 2] != ets_pkg::CMD_NONE) begin
            s_nxt.mode = avs_writedata[ets_pkg::CTRL_CMD +: 2];
            do_restart = 1'b1;
          end
        end
        ets_pkg::REG_TIMING: begin
          s_nxt.frate = avs_writedata[ets_pkg::TIM_FRATE +: 4];
          s_nxt.fcnt  = avs_writedata[ets_pkg::TIM_FCNT +: 5];
          s_nxt.trate = avs_writedata[ets_pkg::TIM_TRATE +: 6];
          s_nxt.tcnt  = avs_writedata[ets_pkg::TIM_TCNT +: 5];
        end
        ets_pkg::REG_STATUS: s_nxt.stat = s_r.stat & ~avs_writedata[4:0];
        default: ;
      endcase
    end
    // ----------------------------------------
    // Sample scheduling
    // ----------------------------------------
    utick = 1'b0;
    stick = 1'b0;
    if (s_r.state != ets_pkg::S_IDLE) begin
      utick = s_r.unit_cnt == 16'(UNIT_CYC - 1);
      s_nxt.unit_cnt = utick ? 16'h0000 : s_r.unit_cnt + 16'h0001;
      if (utick) begin
        stick = s_r.step_div == s_r.frate;
        s_nxt.step_div = stick ? 4'h0 : s_r.step_div + 4'h1;
      end
      if (fuse && !s_r.fpend && s_r.fsched < ftot && (s_r.first ? utick : stick)) begin
        s_nxt.ftimer = s_r.ftimer + 11'h001;
        if (s_r.ftimer + 11'h001 >= s_r.ftarget) begin
          s_nxt.fpend   = 1'b1;
          s_nxt.first   = 1'b0;
          s_nxt.fsched  = s_r.fsched + 6'h01;
          s_nxt.ftimer  = 11'h000;
          s_nxt.ftarget = rnd_steps(s_r.lfsr);
          s_nxt.lfsr    = {s_r.lfsr[7:0], s_r.lfsr[8] ^ s_r.lfsr[4]};
        end
      end
      if (tuse && !s_r.tpend && s_r.tsched < ttot && utick) begin
        s_nxt.ttimer = s_r.ttimer + 15'h0001;
        if (s_r.ttimer + 15'h0001 >= tlim) begin
          s_nxt.tpend  = 1'b1;
          s_nxt.tsched = s_r.tsched + 6'h01;
          s_nxt.ttimer = 15'h0000;
        end
      end
    end
    fin = (!fuse || s_r.fissued == ftot) && (!tuse || s_r.tissued == ttot);
    // ----------------------------------------
    // Command sequencing
    // ----------------------------------------
    unique case (s_r.state)
      ets_pkg::S_IDLE: ;
      ets_pkg::S_RUN: begin
        if (s_r.fpend) begin
          s_nxt.fpend = 1'b0;
          s_nxt.cal_tmp = 1'b0;
          if (s_r.cal_en) begin
            s_nxt.cstart = 1'b1;
            s_nxt.state  = ets_pkg::S_CAL;
          end else begin
            s_nxt.fstart = 1'b1;
            s_nxt.state  = ets_pkg::S_FLIGHT;
          end
        end else if (s_r.tpend) begin
          s_nxt.tpend = 1'b0;
          s_nxt.cal_tmp = 1'b1;
          if (s_r.cal_en) begin
            s_nxt.cstart = 1'b1;
            s_nxt.state  = ets_pkg::S_CAL;
          end else begin
            s_nxt.tstart = 1'b1;
            s_nxt.state  = ets_pkg::S_TEMP;
          end
        end else if (fin) begin
          if (s_r.cont) do_restart = 1'b1;
          else s_nxt.state = ets_pkg::S_IDLE;
        end
      end
      ets_pkg::S_CAL: begin
        if (cal_done) begin
          s_nxt.fstart = ~s_r.cal_tmp;
          s_nxt.tstart = s_r.cal_tmp;
          s_nxt.state  = s_r.cal_tmp ? ets_pkg::S_TEMP : ets_pkg::S_FLIGHT;
        end
      end
      ets_pkg::S_FLIGHT: begin
        if (flight_done) begin
          s_nxt.fissued = s_r.fissued + 6'h01;
          s_nxt.stat[ets_pkg::ST_FMEAS] = 1'b1;
          if (!flight_error) begin
            s_nxt.fvalid = s_r.fvalid + 6'h01;
            s_nxt.fsum   = dsum;
            s_nxt.favg   = avg_of(dsum, s_r.fvalid + 6'h01, 1'b1);
            if (s_r.fvalid == 6'h00 || $signed(diff) > $signed(s_r.fmax)) s_nxt.fmax = diff;
            if (s_r.fvalid == 6'h00 || $signed(diff) < $signed(s_r.fmin)) s_nxt.fmin = diff;
            s_nxt.fspread = 16'(s_nxt.fmax - s_nxt.fmin);
          end
          if (s_r.fissued + 6'h01 == ftot) s_nxt.stat[ets_pkg::ST_FDONE] = 1'b1;
          s_nxt.state = ets_pkg::S_RUN;
        end
      end
      ets_pkg::S_TEMP: begin
        s_nxt.tcyc = s_r.tcyc + 16'h0001;
        if (temp_error_other) begin
          s_nxt.tres0 = ets_pkg::OPEN_VAL;
          s_nxt.tres1 = ets_pkg::OPEN_VAL;
          bad_now = 1'b1;
          last_port = 1'b1;
        end else if (!timing_cap_pin || s_r.tcyc >= port_lim(s_r.pct) + 16'(ets_pkg::OPEN_CYC)) begin
          last_port = s_r.tport;
          if (timing_cap_pin) begin
            pres = ets_pkg::OPEN_VAL;
            bad_now = 1'b1;
            s_nxt.stat[ets_pkg::ST_TMO] = 1'b1;
          end else if (s_r.tcyc < 16'(ets_pkg::SHORT_CYC)) begin
            pres = ets_pkg::SHORT_VAL;
            bad_now = 1'b1;
          end else begin
            pres = s_r.tcyc;
          end
          if (s_r.tport) s_nxt.tres1 = pres;
          else s_nxt.tres0 = pres;
          s_nxt.tport = 1'b1;
          s_nxt.tcyc  = 16'h0000;
          s_nxt.tbad  = s_r.tbad | bad_now;
        end
        if (last_port) begin
          s_nxt.tissued = s_r.tissued + 6'h01;
          s_nxt.stat[ets_pkg::ST_TMEAS] = 1'b1;
          if (!(s_r.tbad | bad_now)) begin
            s_nxt.tvalid = s_r.tvalid + 6'h01;
            s_nxt.tsum0  = 21'(s_r.tsum0 + {5'h00, s_nxt.tres0});
            s_nxt.tsum1  = 21'(s_r.tsum1 + {5'h00, s_nxt.tres1});
            s_nxt.tavg0  = avg_of(s_nxt.tsum0, s_r.tvalid + 6'h01, 1'b0);
            s_nxt.tavg1  = avg_of(s_nxt.tsum1, s_r.tvalid + 6'h01, 1'b0);
          end
          if (s_r.tissued + 6'h01 == ttot) s_nxt.stat[ets_pkg::ST_TDONE] = 1'b1;
          s_nxt.state = ets_pkg::S_RUN;
        end
      end
      default: s_nxt.state = ets_pkg::S_IDLE;
    endcase
    if (s_nxt.tstart) begin
      s_nxt.tport = 1'b0;
      s_nxt.tcyc  = 16'h0000;
      s_nxt.tbad  = 1'b0;
    end
    if (do_restart) begin
      s_nxt.state    = ets_pkg::S_RUN;
      s_nxt.unit_cnt = 16'h0000;
      s_nxt.step_div = 4'h0;
      s_nxt.first    = 1'b1;
      s_nxt.ftimer   = 11'h000;
      s_nxt.ftarget  = 11'(ets_pkg::FIRST_UNITS / ({28'h0, s_nxt.frate} + 32'h1));
      s_nxt.ttimer   = 15'h0000;
      s_nxt.fpend    = 1'b0;
      s_nxt.tpend    = 1'b0;
      s_nxt.fsched   = 6'h00;
      s_nxt.fissued  = 6'h00;
      s_nxt.fvalid   = 6'h00;
      s_nxt.tsched   = 6'h00;
      s_nxt.tissued  = 6'h00;
      s_nxt.tvalid   = 6'h00;
      s_nxt.fsum     = 21'h000000;
      s_nxt.tsum0    = 21'h000000;
      s_nxt.tsum1    = 21'h000000;
      s_nxt.fspread  = 16'h0000;
    end
    s_nxt.irq_n = ~(s_nxt.irqen & (s_nxt.stat[ets_pkg::ST_FDONE] | s_nxt.stat[ets_pkg::ST_TDONE] |
                  s_nxt.stat[ets_pkg::ST_TMO] | (s_nxt.pmi & (s_nxt.stat[ets_pkg::ST_FMEAS] |
                  s_nxt.stat[ets_pkg::ST_TMEAS]))));
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r         <= '0;
      s_r.state   <= ets_pkg::S_IDLE;
      s_r.lfsr    <= ets_pkg::LFSR_SEED;
      s_r.first   <= 1'b1;
      s_r.irq_n   <= 1'b1;
      s_r.waitreq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = s_r.waitreq;
  assign flight_start    = s_r.fstart;
  assign cal_start       = s_r.cstart;
  assign temp_start      = s_r.tstart;
  assign temp_port_sel   = s_r.tport;
  assign irq_n           = s_r.irq_n;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_flight_ok;
    s_r.state == ets_pkg::S_FLIGHT && flight_done && !flight_error;
  endsequence
  sequence s_flight_bad;
    s_r.state == ets_pkg::S_FLIGHT && flight_done && flight_error;
  endsequence

  a_short_zero: assert property (
    s_r.state == ets_pkg::S_TEMP && !temp_error_other && !timing_cap_pin && !s_r.tport &&
    s_r.tcyc < 16'(ets_pkg::SHORT_CYC) |=> s_r.tres0 == 16'h0000)
    else $error("short probe did not load zero");
  a_open_flag: assert property (
    s_r.state == ets_pkg::S_TEMP && !temp_error_other && timing_cap_pin && s_r.irqen &&
    s_r.tcyc >= port_lim(s_r.pct) + 16'(ets_pkg::OPEN_CYC) |=> s_r.stat[ets_pkg::ST_TMO] && !irq_n)
    else $error("open probe did not flag timeout");
  a_other_all: assert property (
    s_r.state == ets_pkg::S_TEMP && temp_error_other |=> s_r.tres0 == 16'hFFFF && s_r.tres1 == 16'hFFFF)
    else $error("other temperature failure not marked on all ports");
  a_stop_once: assert property (
    s_r.state == ets_pkg::S_RUN && !s_r.fpend && !s_r.tpend && fin && !s_r.cont && !wr_ok
    |=> s_r.state == ets_pkg::S_IDLE)
    else $error("single sequence did not stop");
  a_cont_again: assert property (
    s_r.state == ets_pkg::S_RUN && !s_r.fpend && !s_r.tpend && fin && s_r.cont && !wr_ok
    |=> s_r.state == ets_pkg::S_RUN && s_r.fissued == 6'h00 && s_r.tissued == 6'h00)
    else $error("continuous sequence did not restart");
  a_meas_irq: assert property (
    s_flight_ok ##0 (s_r.pmi && s_r.irqen && !wr_ok) |=> !irq_n)
    else $error("per-measurement interrupt missing");
  a_lfsr_live: assert property (s_r.lfsr != 9'h000)
    else $error("randomizer locked at zero");
  a_rand_range: assert property (
    !s_r.first |-> s_r.ftarget >= 11'(ets_pkg::RAND_MIN_STEPS) && s_r.ftarget <= 11'h1FF)
    else $error("random interval out of range");
  a_count_hold: assert property (
    s_flight_bad ##0 !do_restart |=> $stable(s_r.fvalid))
    else $error("flight count moved on error");
  a_count_step: assert property (
    s_flight_ok |=> s_r.fvalid == $past(s_r.fvalid) + 6'h01)
    else $error("flight count did not step");
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
endmodule : ets_sequencer

// File: bench/ets_engine_model.sv
// Far-side engines answering the sequencer's start pulses.
// Assumes the bench sets outcomes; results are garbage outside done.
`timescale 1ns/1ps
module ets_engine_model (
  // Clock
  input  logic        clk,
  // Sequencer side
  input  logic        flight_start,
  output logic        flight_done,
  output logic        flight_error,
  output logic [15:0] upstream_average,
  output logic [15:0] downstream_average,
  input  logic        cal_start,
  output logic        cal_done,
  input  logic        temp_start,
  input  logic        temp_port_sel,
  output logic        timing_cap_pin,
  // Bench controls
  input  logic [3:0]  err_mask,
  input  logic [15:0] p0_cyc,
  input  logic [15:0] p1_cyc
);
  logic [2:0]  fd_r = 3'h0;
  logic [1:0]  cd_r = 2'h0;
  logic [2:0]  idx_r = 3'h0;
  logic [15:0] dis_r = 16'h0000;
  logic        sel_r = 1'b0;
  logic        rst_cnt;
  logic [15:0] k, dis;
  assign k                  = {9'h000, idx_r, 4'h0};
  assign cal_done           = cd_r[1];
  assign flight_done        = fd_r[2];
  assign flight_error       = err_mask[idx_r[1:0]] ^ !flight_done;
  assign upstream_average   = flight_done ? 16'h1000 + k : ~k;
  assign downstream_average = flight_done ? 16'h1000 - k : k;
  // Pin stays above threshold until the port's discharge time
  // Count restarts with each port so it tracks the sequencer's own count
  assign rst_cnt            = temp_start || temp_port_sel != sel_r;
  assign dis                = rst_cnt ? 16'h0000 : dis_r;
  assign timing_cap_pin     = dis < (temp_port_sel ? p1_cyc : p0_cyc);
  always_ff @(posedge clk) begin
    fd_r  <= {fd_r[1:0], flight_start};
    cd_r  <= {cd_r[0], cal_start};
    idx_r <= idx_r + {2'h0, flight_done};
    sel_r <= temp_port_sel;
    if (rst_cnt)
      dis_r <= 16'h0001;
    else if (dis_r != 16'hFFFF)
      dis_r <= dis_r + 16'h0001;
  end
endmodule : ets_engine_model

// File: bench/event_timing_sequencer_tb.sv
// Self-checking bench of the event timing sequencer.
// Assumes the engine model on the far side and UNIT_CYC cut to 4.
`timescale 1ns/1ps
module event_timing_sequencer_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, flight_start, flight_done, flight_error, cal_start, cal_done;
  logic        temp_start, temp_port_sel, timing_cap_pin, irq_n;
  logic        temp_error_other = 1'b0;
  logic [15:0] upstream_average, downstream_average;
  logic [15:0] p0_cyc = 16'h0032;
  logic [15:0] p1_cyc = 16'hFFFF;
  logic [3:0]  err_mask = 4'h2;
  int          mismatches = 0, tests_run = 0, cyc = 0, starts = 0;
  int          st [0:7];
  ets_sequencer #(.UNIT_CYC(4)) u_dut (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .flight_start, .flight_done,
    .flight_error, .upstream_average, .downstream_average, .cal_start, .cal_done,
    .temp_start, .temp_port_sel, .timing_cap_pin, .temp_error_other, .irq_n);
  ets_engine_model u_eng (.clk, .flight_start, .flight_done, .flight_error,
    .upstream_average, .downstream_average, .cal_start, .cal_done, .temp_start, .temp_port_sel,
    .timing_cap_pin, .err_mask, .p0_cyc, .p1_cyc);
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (flight_start === 1'b1) begin
      st[starts % 8] <= cyc;
      starts         <= starts + 1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_n !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("irq_n low", 0, {31'h0, irq_n});
    repeat (4) @(posedge clk);
  endtask : wait_irq
  task automatic t_reset;
    bus(0, ets_pkg::REG_CTRL, 0);
    chk("ctrl", ets_pkg::CTRL_RST, rd);
    bus(0, 4'hC, 0);
    chk("unmapped", 0, rd);
  endtask : t_reset
  task automatic t_flight;
    int t0;
    bus(1, ets_pkg::REG_TIMING, 32'h0000_0200);
    t0 = cyc;
    bus(1, ets_pkg::REG_CTRL, 32'h0000_0042);
    wait_irq(20000);
    chk("starts", 3, starts);
    chk("first", 1, st[0] - t0 > 4088 && st[0] - t0 < 4112);
    chk("gap", 1, st[1] - st[0] > 167 && st[1] - st[0] < 2053);
    bus(0, ets_pkg::REG_FSTAT, 0);
    chk("count spread", 32'h0040_0002, rd);
    bus(0, ets_pkg::REG_DAVG, 0);
    chk("diff avg", 32'h0000_0020, rd);
    bus(0, ets_pkg::REG_STATUS, 0);
    chk("done", 32'h0000_0001, rd & 32'h0000_0101);
    bus(1, ets_pkg::REG_STATUS, 32'h0000_001F);
    repeat (3000) @(posedge clk);
    chk("stopped", 1, starts == 3 && irq_n === 1'b1);
  endtask : t_flight
  task automatic t_temp;
    bus(1, ets_pkg::REG_TIMING, 0);
    bus(1, ets_pkg::REG_CTRL, 32'h0000_0063);
    wait_irq(9000);
    bus(0, ets_pkg::REG_TRES, 0);
    chk("short open", 32'hFFFF_0000, rd);
    bus(0, ets_pkg::REG_STATUS, 0);
    chk("timeout", 32'h0000_0004, rd & 32'h0000_0004);
    bus(0, ets_pkg::REG_TAVG, 0);
    chk("tavg", 0, rd);
    bus(1, ets_pkg::REG_STATUS, 32'h0000_001F);
    p0_cyc <= 16'h0190;
    p1_cyc <= 16'h01F4;
    bus(1, ets_pkg::REG_TIMING, 32'h0100_0000);
    bus(1, ets_pkg::REG_CTRL, 32'h0000_0063);
    wait_irq(3000);
    bus(0, ets_pkg::REG_TRES, 0);
    chk("valid res", 32'h01F4_0190, rd);
    bus(0, ets_pkg::REG_TCNT, 0);
    chk("tcount one", 1, rd);
    bus(1, ets_pkg::REG_STATUS, 32'h0000_001F);
    while (temp_start !== 1'b1) @(posedge clk);
    repeat (300) @(posedge clk);
    temp_error_other <= 1'b1;
    @(posedge clk);
    temp_error_other <= 1'b0;
    wait_irq(3000);
    bus(0, ets_pkg::REG_TRES, 0);
    chk("other fail", 32'hFFFF_FFFF, rd);
    bus(0, ets_pkg::REG_TAVG, 0);
    chk("tavg kept", 32'h01F4_0190, rd);
    bus(0, ets_pkg::REG_TCNT, 0);
    chk("tcount", 1, rd);
    bus(1, ets_pkg::REG_STATUS, 32'h0000_001F);
  endtask : t_temp
  task automatic t_both;
    int s0;
    s0 = starts;
    err_mask <= 4'h0;
    bus(1, ets_pkg::REG_TIMING, 0);
    bus(1, ets_pkg::REG_CTRL, 32'h0000_1041);
    wait_irq(3000);
    bus(0, ets_pkg::REG_STATUS, 0);
    chk("temp first", 32'h0000_0102, rd & 32'h0000_0103);
    bus(1, ets_pkg::REG_STATUS, 32'h0000_001F);
    wait_irq(5000);
    chk("cal flight", s0 + 1, starts);
    bus(0, ets_pkg::REG_STATUS, 0);
    chk("both done", 32'h0000_0001, rd & 32'h0000_0103);
    bus(1, ets_pkg::REG_STATUS, 32'h0000_001F);
  endtask : t_both
  task automatic t_cont;
    err_mask <= 4'h0;
    bus(1, ets_pkg::REG_TIMING, 32'h0000_0100);
    bus(1, ets_pkg::REG_CTRL, 32'h0000_0072);
    wait_irq(9000);
    bus(0, ets_pkg::REG_STATUS, 0);
    chk("per meas", 32'h0000_0108, rd & 32'h0000_0109);
    bus(1, ets_pkg::REG_STATUS, 32'h0000_001F);
    wait_irq(5000);
    bus(1, ets_pkg::REG_STATUS, 32'h0000_001F);
    wait_irq(9000);
    bus(0, ets_pkg::REG_STATUS, 0);
    chk("restart", 32'h0000_0108, rd & 32'h0000_0109);
    bus(1, ets_pkg::REG_CTRL, 32'h0000_0004);
    repeat (20) @(posedge clk);
    bus(0, ets_pkg::REG_STATUS, 0);
    chk("halted", 0, rd & 32'h0000_0100);
  endtask : t_cont
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_flight;
    t_temp;
    t_both;
    t_cont;
    report_and_stop;
  end
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end
endmodule : event_timing_sequencer_tb
